//--- verilog/tcb_defines.svh
`ifndef TCB_DEFINES_SVH
`define TCB_DEFINES_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define TCB_OFS_T01_CTL 8'h00
`define TCB_OFS_T0_CNT 8'h04
`define TCB_OFS_T1_CNT 8'h08
`define TCB_OFS_STATUS 8'h10
`define TCB_OFS_TX_BASE 8'h20
`define TCB_OFS_TX_STEP 8'h10
`define TCB_OFS_TX_CTL 8'h00
`define TCB_OFS_TX_CNT 8'h04
`define TCB_OFS_TX_RCAP 8'h08
// ****************************************************************
// control byte field positions
// ****************************************************************
`define TCB_F_MODE_LSB 0
`define TCB_F_CTR 3
`define TCB_F_RUN 4
`define TCB_F_TOG 5
`define TCB_F_HIRUN 6
`define TCB_F_EXTEN 6
// ****************************************************************
// status bit positions
// ****************************************************************
`define TCB_S_T0HI 5
// ****************************************************************
// reset values and timing
// ****************************************************************
`define TCB_RST_CTL 8'h00
`define TCB_RST_CNT 16'h0000
`define TCB_MC_DIV 2
`endif

//--- verilog/tcb_pkg.sv
// ****************************************************************
// shared types of the timer bank
// ****************************************************************
package tcb_pkg;
    // modes of timers 0 and 1
    typedef enum logic [2:0] {
        TCB_M0 = 3'h0,
        TCB_M1 = 3'h1,
        TCB_M2 = 3'h2,
        TCB_M3 = 3'h3,
        TCB_M6 = 3'h6
    } tcb_m01_t;
    // modes of timers 2 to 4
    typedef enum logic [1:0] {
        TCB_X_RELOAD = 2'h0,
        TCB_X_CAPTURE = 2'h1,
        TCB_X_FREE = 2'h2
    } tcb_mx_t;
endpackage

//--- verilog/tcb_t16_if.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// link between the bank and one 16-bit timer
// ****************************************************************
interface tcb_t16_if;
    logic [1:0] mode;   // operating mode
    logic tick;         // count strobe
    logic ext_fall;     // falling edge on trigger pin
    logic ext_en;       // trigger pin enable
    logic tog_en;       // overflow toggle enable
    logic cnt_wr;       // software count write
    logic rcap_wr;      // software reload/capture write
    logic [15:0] wdata; // merged write data
    logic [15:0] cnt;   // count value
    logic [15:0] rcap;  // reload/capture value
    logic ovf;          // overflow pulse
    logic pin_o;        // toggle pin level
    modport ctl (output mode, tick, ext_fall, ext_en, tog_en, cnt_wr, rcap_wr, wdata,
                 input cnt, rcap, ovf, pin_o);
    modport tmr (input mode, tick, ext_fall, ext_en, tog_en, cnt_wr, rcap_wr, wdata,
                 output cnt, rcap, ovf, pin_o);
endinterface
`default_nettype wire

//--- verilog/tcb_t16.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcb_defines.svh"
// ****************************************************************
// one 16-bit timer with reload or capture
// ****************************************************************
module tcb_t16 (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    tcb_t16_if.tmr bus
);
    logic [15:0] cnt_ff;  // count register
    logic [15:0] rcap_ff; // reload/capture register
    logic tog_ff;         // toggle output level
    logic wrap;           // count at all ones
    logic ext_go;         // qualified trigger edge

    assign wrap = (cnt_ff == 16'hFFFF);
    assign ext_go = bus.ext_fall & bus.ext_en;
    // overflow on a strobe at all ones, unless a software count write takes the cycle
    assign bus.ovf = bus.tick & wrap & ~bus.cnt_wr;
    assign bus.cnt = cnt_ff;
    assign bus.rcap = rcap_ff;
    // a released pin reads high at once, not one cycle later
    assign bus.pin_o = tog_ff | ~bus.tog_en;

    // count register: software write, trigger reload, then counting
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_ff <= `TCB_RST_CNT;
        end else if (clk_en) begin
            if (bus.cnt_wr) begin
                cnt_ff <= bus.wdata;
            end else if (ext_go && bus.mode == tcb_pkg::TCB_X_RELOAD) begin
                cnt_ff <= rcap_ff;
            end else if (bus.tick) begin
                if (wrap && bus.mode == tcb_pkg::TCB_X_RELOAD) begin
                    cnt_ff <= rcap_ff;
                end else begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end
        end
    end

    // reload/capture register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rcap_ff <= `TCB_RST_CNT;
        end else if (clk_en) begin
            if (bus.rcap_wr) begin
                rcap_ff <= bus.wdata;
            end else if (ext_go && bus.mode == tcb_pkg::TCB_X_CAPTURE) begin
                rcap_ff <= cnt_ff;
            end
        end
    end

    // toggle output: high while disabled, flips on each overflow
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tog_ff <= 1'b1;
        end else if (clk_en) begin
            if (!bus.tog_en) begin
                tog_ff <= 1'b1;
            end else if (bus.ovf) begin
                tog_ff <= ~tog_ff;
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/tcb_timer_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcb_defines.svh"
module tcb_timer_bank #(
    parameter int MC_DIV = `TCB_MC_DIV
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_zero_pin_i,
    output logic timer_zero_pin_o,
    output logic timer_zero_pin_oe,
    input wire logic timer_one_pin_i,
    output logic timer_one_pin_o,
    output logic timer_one_pin_oe,
    input wire logic [2:0] timer_x_pin_i,
    output logic [2:0] timer_x_pin_o,
    output logic [2:0] timer_x_pin_oe,
    input wire logic [2:0] ext_reload_capture_pin_i,
    output logic [5:0] timer_flag_o
);
    // ****************************************************************
    // helper functions
    // ****************************************************************
    // merge write data into a 16-bit value under byte enables
    function automatic logic [15:0] f_merge16(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction
    // one count step of timer 0/1 low part; returns {overflow, next}
    function automatic logic [16:0] f_step(input logic [2:0] mode,
                                           input logic [15:0] c);
        logic [15:0] n;
        logic o;
        logic [13:0] s13;
        logic [8:0] s8;
        n = c;
        o = 1'b0;
        s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
        s8 = {1'b0, c[7:0]} + 9'h001;
        unique case (mode)
            tcb_pkg::TCB_M0: begin
                // 5-bit prescaler in low bits, 8-bit counter above
                {o, n[15:8], n[4:0]} = s13;
            end
            tcb_pkg::TCB_M1: begin
                {o, n} = {1'b0, c} + 17'h00001;
            end
            tcb_pkg::TCB_M2: begin
                o = s8[8];
                n[7:0] = s8[8] ? c[15:8] : s8[7:0];
            end
            tcb_pkg::TCB_M3, tcb_pkg::TCB_M6: begin
                // free 8-bit wrap: 256 count strobes per period
                {o, n[7:0]} = s8;
            end
            default: begin
                // unused mode codes hold the count
                n = c;
            end
        endcase
        return {o, n};
    endfunction
    // ****************************************************************
    // machine cycle strobe
    // ****************************************************************
    logic [3:0] mc_cnt_ff; // divider for machine cycle
    logic mc_tick;         // one clock per machine cycle
    assign mc_tick = (mc_cnt_ff == 4'(MC_DIV - 1));
    // free-running divider; the peripheral clock uses the same rate
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mc_cnt_ff <= 4'h0;
        end else if (clk_en) begin
            mc_cnt_ff <= mc_tick ? 4'h0 : mc_cnt_ff + 4'h1;
        end
    end
    // ****************************************************************
    // pin input synchronisers and falling-edge detect
    // ****************************************************************
    logic [7:0] pin_raw;  // {trigger[2:0], tx[2:0], t1, t0}
    logic [7:0] s1_ff;    // first stage
    logic [7:0] s2_ff;    // second stage
    logic [7:0] s3_ff;    // third stage
    logic [7:0] lvl_ff;   // accepted level
    logic [7:0] fall;     // one-clock falling edge on the machine cycle strobe
    assign pin_raw = {ext_reload_capture_pin_i, timer_x_pin_i,
                      timer_one_pin_i, timer_zero_pin_i};
    // three-stage synchroniser
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s1_ff <= 8'hFF;
            s2_ff <= 8'hFF;
            s3_ff <= 8'hFF;
        end else if (clk_en) begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // edge counts once stages two and three agree, one sample per machine cycle
    assign fall = {8{mc_tick}} & ~(s2_ff ^ s3_ff) & lvl_ff & ~s3_ff;
    // accepted level, sampled once per machine cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lvl_ff <= 8'hFF;
        end else if (clk_en && mc_tick) begin
            lvl_ff <= (lvl_ff & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));
        end
    end
    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    logic ack_ff;          // answer strobe
    logic [31:0] dat_ff;   // read data
    logic req;             // request pending, not yet answered
    logic wr_go;           // write commits with the answer
    logic [31:0] rd_mux;   // read data selected by address
    logic [7:0] t01_ctl_ff [2];  // timer 0/1 control bytes
    logic [7:0] tx_ctl_ff [3];   // timer 2-4 control bytes
    logic [15:0] t01_cnt_ff [2]; // timer 0/1 counts
    logic [5:0] flag_ff;         // sticky overflow flags
    logic [5:0] flag_set;        // overflow events this cycle
    logic [15:0] tx_cnt [3];     // timer 2-4 counts
    logic [15:0] tx_rcap [3];    // timer 2-4 reload/capture values
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    // answer one cycle after the request, for one cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else if (clk_en) begin
            ack_ff <= req;
        end
    end
    // read data decode; unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            `TCB_OFS_T01_CTL: rd_mux = {16'h0000, t01_ctl_ff[1], t01_ctl_ff[0]};
            `TCB_OFS_T0_CNT: rd_mux = {16'h0000, t01_cnt_ff[0]};
            `TCB_OFS_T1_CNT: rd_mux = {16'h0000, t01_cnt_ff[1]};
            `TCB_OFS_STATUS: rd_mux = {26'h0, flag_ff};
            default: begin
                for (int k = 0; k < 3; k++) begin
                    if (wb_adr_i == 8'(`TCB_OFS_TX_BASE + k * `TCB_OFS_TX_STEP
                                        + `TCB_OFS_TX_CTL)) begin
                        rd_mux = {24'h0, tx_ctl_ff[k]};
                    end
                    if (wb_adr_i == 8'(`TCB_OFS_TX_BASE + k * `TCB_OFS_TX_STEP
                                        + `TCB_OFS_TX_CNT)) begin
                        rd_mux = {16'h0, tx_cnt[k]};
                    end
                    if (wb_adr_i == 8'(`TCB_OFS_TX_BASE + k * `TCB_OFS_TX_STEP
                                        + `TCB_OFS_TX_RCAP)) begin
                        rd_mux = {16'h0, tx_rcap[k]};
                    end
                end
            end
        endcase
    end
    // read data taken at the request, shown with the answer
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dat_ff <= 32'h0000_0000;
        end else if (clk_en && req) begin
            dat_ff <= wb_we_i ? 32'h0000_0000 : rd_mux;
        end
    end
    // ****************************************************************
    // control registers
    // ****************************************************************
    // timer 0/1 control bytes, byte lanes 0 and 1
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            t01_ctl_ff[0] <= `TCB_RST_CTL;
            t01_ctl_ff[1] <= `TCB_RST_CTL;
        end else if (clk_en && wr_go && wb_adr_i == `TCB_OFS_T01_CTL) begin
            if (wb_sel_i[0]) begin
                t01_ctl_ff[0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                t01_ctl_ff[1] <= wb_dat_i[15:8];
            end
        end
    end
    // timer 2-4 control bytes
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int k = 0; k < 3; k++) begin
                tx_ctl_ff[k] <= `TCB_RST_CTL;
            end
        end else if (clk_en && wr_go && wb_sel_i[0]) begin
            for (int k = 0; k < 3; k++) begin
                if (wb_adr_i == 8'(`TCB_OFS_TX_BASE + k * `TCB_OFS_TX_STEP
                                    + `TCB_OFS_TX_CTL)) begin
                    tx_ctl_ff[k] <= wb_dat_i[7:0];
                end
            end
        end
    end

    // sticky flags: an event in the clearing cycle wins over the clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flag_ff <= 6'h00;
        end else if (clk_en) begin
            if (wr_go && wb_adr_i == `TCB_OFS_STATUS && wb_sel_i[0]) begin
                flag_ff <= (flag_ff & ~wb_dat_i[5:0]) | flag_set;
            end else begin
                flag_ff <= flag_ff | flag_set;
            end
        end
    end
    assign timer_flag_o = flag_ff;
    // ****************************************************************
    // timers 0 and 1
    // ****************************************************************
    logic [1:0] t01_tick;    // low part count strobe
    logic [1:0] t01_ovf;     // low part overflow
    logic t0_hi_tick;        // timer 0 high byte strobe in mode 3
    logic t0_hi_ovf;         // timer 0 high byte overflow
    logic [16:0] t01_nxt [2]; // step results
    logic [1:0] t01_tog_ff;  // toggle output levels
    logic [1:0] t01_pwm;     // pwm output levels
    logic [1:0] t01_pin;     // final pin levels
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // machine cycle or falling count-pin edge
            t01_tick[i] = t01_ctl_ff[i][`TCB_F_RUN]
                        & (t01_ctl_ff[i][`TCB_F_CTR] ? fall[i] : mc_tick);
            t01_nxt[i] = f_step(t01_ctl_ff[i][2:0], t01_cnt_ff[i]);
            // pwm: high while low byte is below the high byte
            t01_pwm[i] = (t01_cnt_ff[i][7:0] < t01_cnt_ff[i][15:8]);
            // a released pin reads high in every mode
            t01_pin[i] = ~t01_ctl_ff[i][`TCB_F_TOG]
                       | ((t01_ctl_ff[i][2:0] == tcb_pkg::TCB_M6) ? t01_pwm[i]
                                                                  : t01_tog_ff[i]);
        end
        // timer 1 in mode 3 holds its count; baud use reads the count as is
        if (t01_ctl_ff[1][2:0] == tcb_pkg::TCB_M3) begin
            t01_tick[1] = 1'b0;
        end
        t01_ovf[0] = t01_tick[0] & t01_nxt[0][16];
        t01_ovf[1] = t01_tick[1] & t01_nxt[1][16];
    end
    // timer 0 high byte runs alone in mode 3 on machine cycles
    assign t0_hi_tick = (t01_ctl_ff[0][2:0] == tcb_pkg::TCB_M3)
                      & t01_ctl_ff[0][`TCB_F_HIRUN] & mc_tick;
    assign t0_hi_ovf = t0_hi_tick & (t01_cnt_ff[0][15:8] == 8'hFF);
    // counts: software write first, then counting
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            t01_cnt_ff[0] <= `TCB_RST_CNT;
            t01_cnt_ff[1] <= `TCB_RST_CNT;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (wr_go && wb_adr_i == 8'(`TCB_OFS_T0_CNT + 4 * i)) begin
                    t01_cnt_ff[i] <= f_merge16(t01_cnt_ff[i], wb_dat_i, wb_sel_i);
                end else begin
                    if (t01_tick[i]) begin
                        t01_cnt_ff[i] <= t01_nxt[i][15:0];
                    end
                    if (i == 0 && t0_hi_tick) begin
                        // second 8-bit counter in the high byte
                        t01_cnt_ff[0][15:8] <= t01_cnt_ff[0][15:8] + 8'h01;
                    end
                end
            end
        end
    end

    // toggle outputs: held high until the first overflow
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            t01_tog_ff <= 2'b11;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (!t01_ctl_ff[i][`TCB_F_TOG]) begin
                    t01_tog_ff[i] <= 1'b1;
                end else if (t01_ovf[i]) begin
                    t01_tog_ff[i] <= ~t01_tog_ff[i];
                end
            end
        end
    end

    // the count pin doubles as toggle output when enabled
    assign timer_zero_pin_o = t01_pin[0];
    assign timer_zero_pin_oe = t01_ctl_ff[0][`TCB_F_TOG];
    assign timer_one_pin_o = t01_pin[1];
    assign timer_one_pin_oe = t01_ctl_ff[1][`TCB_F_TOG];
    // ****************************************************************
    // timers 2 to 4
    // ****************************************************************
    logic [2:0] tx_ovf; // overflow pulses
    for (genvar k = 0; k < 3; k++) begin : g_tx
        tcb_t16_if tbus ();
        assign tbus.mode = tx_ctl_ff[k][1:0];
        // peripheral clock or falling count-pin edge
        assign tbus.tick = tx_ctl_ff[k][`TCB_F_RUN]
                         & (tx_ctl_ff[k][`TCB_F_CTR] ? fall[2 + k] : mc_tick);
        assign tbus.ext_fall = fall[5 + k];
        assign tbus.ext_en = tx_ctl_ff[k][`TCB_F_EXTEN];
        assign tbus.tog_en = tx_ctl_ff[k][`TCB_F_TOG];
        assign tbus.cnt_wr = wr_go & (wb_adr_i == 8'(`TCB_OFS_TX_BASE
                             + k * `TCB_OFS_TX_STEP + `TCB_OFS_TX_CNT));
        assign tbus.rcap_wr = wr_go & (wb_adr_i == 8'(`TCB_OFS_TX_BASE
                              + k * `TCB_OFS_TX_STEP + `TCB_OFS_TX_RCAP));
        assign tbus.wdata = f_merge16(tbus.cnt_wr ? tbus.cnt : tbus.rcap,
                                      wb_dat_i, wb_sel_i);
        assign tx_cnt[k] = tbus.cnt;
        assign tx_rcap[k] = tbus.rcap;
        assign tx_ovf[k] = tbus.ovf;
        assign timer_x_pin_o[k] = tbus.pin_o;
        assign timer_x_pin_oe[k] = tx_ctl_ff[k][`TCB_F_TOG];
        tcb_t16 u_t16 (
            .clock(clock),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .bus(tbus)
        );
    end
    // overflow events gathered for the flags
    assign flag_set = {t0_hi_ovf, tx_ovf, t01_ovf};
endmodule
`default_nettype wire

//--- tb/tcb_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// far-side count and trigger pins
// ****
module tcb_pins_model (
    input wire logic clock,
    input wire logic [7:0] pin_req,
    output logic [7:0] pin_lvl
);
    logic [3:0] cnt_ff = 4'h0; // low-phase length left
    logic [7:0] low_ff = 8'h00; // pins pulled low now
    // lines idle high; a request drops the chosen lines
    assign pin_lvl = ~low_ff;
    // low phase of seven clocks, well over two machine cycles
    always_ff @(posedge clock) begin
        if (pin_req != 8'h00) begin
            low_ff <= pin_req;
            cnt_ff <= 4'h6;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else begin
            low_ff <= 8'h00;
        end
    end
endmodule
`default_nettype wire

//--- tb/tcb_timer_bank_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bus and toggle pin checks
// ****
module tcb_timer_bank_sva (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic timer_zero_pin_o,
    input wire logic timer_zero_pin_oe,
    input wire logic [2:0] timer_x_pin_o,
    input wire logic [2:0] timer_x_pin_oe,
    input wire logic [5:0] timer_flag_o
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // request waiting for its answer
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
    endsequence
    // a one-cycle answer
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_follows_a: assert property (bus_req |=> ack_once) else $error("ack missing");
    ack_idle_a: assert property (!wb_stb_i |=> !wb_ack_o) else $error("ack unasked");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without cycle");
    flag_clear_a: assert property ($past(rst_b) &&
        |($past(timer_flag_o) & ~timer_flag_o) |-> $past(wb_we_i && wb_ack_o))
        else $error("flag lost without write");
    t0_oe_write_a: assert property ($past(rst_b) &&
        $changed(timer_zero_pin_oe) |-> $past(wb_we_i && wb_ack_o))
        else $error("t0 enable moved alone");
    x_oe_write_a: assert property ($past(rst_b) &&
        $changed(timer_x_pin_oe) |-> $past(wb_we_i && wb_ack_o))
        else $error("toggle enable moved alone");
    x_idle_high_a: assert property ((timer_x_pin_o | timer_x_pin_oe) == 3'h7)
        else $error("idle toggle pin low");
    t0_idle_high_a: assert property (!timer_zero_pin_oe |-> timer_zero_pin_o)
        else $error("idle t0 pin low");
endmodule
bind tcb_timer_bank tcb_timer_bank_sva u_tcb_timer_bank_sva (.clock(clock), .rst_b(rst_b),
    .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .timer_zero_pin_o(timer_zero_pin_o),
    .timer_zero_pin_oe(timer_zero_pin_oe), .timer_x_pin_o(timer_x_pin_o),
    .timer_x_pin_oe(timer_x_pin_oe), .timer_flag_o(timer_flag_o));
`default_nettype wire

//--- tb/tcb_timer_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcb_defines.svh"
module tcb_timer_bank_tb_top;
    // ****
    // stimulus, bus and pin signals
    // ****
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0; // cycle and strobe together
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o;
    logic ack;
    logic ce = 1'b1; // clock enable, dropped to freeze the block
    logic [7:0] pin_req = 8'h00;
    logic [7:0] pin_lvl;
    logic z_o, z_oe, o_o, o_oe;
    logic [2:0] x_o, x_oe;
    logic [5:0] flags;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    tcb_timer_bank #(.MC_DIV(2)) u_tcb_timer_bank (.clock(clock), .rst_b(rst_b),
        .clk_en(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .timer_zero_pin_i(pin_lvl[6]), .timer_zero_pin_o(z_o), .timer_zero_pin_oe(z_oe),
        .timer_one_pin_i(pin_lvl[7]), .timer_one_pin_o(o_o), .timer_one_pin_oe(o_oe),
        .timer_x_pin_i(pin_lvl[2:0]), .timer_x_pin_o(x_o), .timer_x_pin_oe(x_oe),
        .ext_reload_capture_pin_i(pin_lvl[5:3]), .timer_flag_o(flags));
    tcb_pins_model u_tcb_pins_model (.clock(clock), .pin_req(pin_req), .pin_lvl(pin_lvl));
    // free-running clock
    initial begin
        forever #2 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is sampled, then a gap
    // ack and read data are taken as sampled at the same edge
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        access(1'b0, a, 32'h0, q);
        check(name, q, exp);
    endtask
    // falling edges on the chosen pins, then wait out the synchroniser
    task automatic pulse(input logic [7:0] m);
        pin_req <= m;
        @(posedge clock);
        pin_req <= 8'h00;
        repeat (20) @(posedge clock);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd("status", `TCB_OFS_STATUS, 32'h0);
        wr(`TCB_OFS_T0_CNT, 32'hFFFF);
        wr(`TCB_OFS_T1_CNT, 32'hFF1F);
        wr(`TCB_OFS_T01_CTL, 32'h1839);
        pulse(8'hC0);
        rd("t0 count", `TCB_OFS_T0_CNT, 32'h0);
        rd("t1 count", `TCB_OFS_T1_CNT, 32'h0);
        check("flags", {26'h0, flags}, 32'h3);
        check("t0 pin", {31'h0, z_o}, 32'h0);
        wr(`TCB_OFS_STATUS, 32'h3F);
        rd("status", `TCB_OFS_STATUS, 32'h0);
        wr(`TCB_OFS_T0_CNT, 32'h80FF);
        wr(`TCB_OFS_T1_CNT, 32'h0055);
        wr(`TCB_OFS_T01_CTL, 32'h1B1A);
        pulse(8'hC0);
        rd("t0 reload", `TCB_OFS_T0_CNT, 32'h8080);
        rd("t1 frozen", `TCB_OFS_T1_CNT, 32'h0055);
        wr(8'h24, 32'hFFFE);
        wr(8'h20, 32'h3A);
        for (int i = 0; i < 3; i++) begin
            pulse(8'h01);
        end
        rd("t2 count", 8'h24, 32'h0001);
        check("t2 pin", {29'h0, x_o}, 32'h6);
        check("t2 flag", {31'h0, flags[2]}, 32'h1);
        ce <= 1'b0;
        pulse(8'h01);
        ce <= 1'b1;
        rd("t2 frozen", 8'h24, 32'h0001);
        wr(8'h34, 32'h1234);
        wr(8'h30, 32'h59);
        pulse(8'h10);
        rd("t3 capture", 8'h38, 32'h1234);
        wr(8'h48, 32'hABCD);
        wr(8'h40, 32'h58);
        pulse(8'h20);
        rd("t4 reload", 8'h44, 32'hABCD);
        wr(`TCB_OFS_T0_CNT, 32'h8000);
        wr(`TCB_OFS_STATUS, 32'h3F);
        wr(`TCB_OFS_T01_CTL, 32'h1B36);
        check("pwm high", {31'h0, z_o}, 32'h1);
        repeat (300) @(posedge clock);
        check("pwm low", {31'h0, z_o}, 32'h0);
        repeat (300) @(posedge clock);
        check("pwm wrap", {30'h0, flags[0], z_o}, 32'h3);
        rd("unmapped", 8'hFC, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
